// file: csa_regs.svh
// constants of the cell stack alarm logic
// Summary of operation
// - cell select 00 six cells, 01 five, 10 four, 11 three; higher taps ignored
// - negative coefficient mode: thermal alarm when either sense input falls below trip
// - positive coefficient mode: thermal alarm when either sense input rises above trip
// - polarity pin low means negative, high positive; comparison direction follows it
// - a crossing beyond a trip level changes the matching alarm level output
// - each alarm state is also driven on the chain alarm current outputs
// - every enabled cell input is window compared to its trip levels; each temperature input to its one trip
// - shared grouping drives all three outputs alike; separate shows own condition only
// - self-test starts only on a request at the self-test request input
// - enable and test requests enter the bottom device; it reports the whole chain
// - chain role comes from the two end straps and shapes chain behaviour
// - programmable deglitch keeps transient cell excursions from raising alarms
// - straps: 00 middle, lower end only bottom, upper end only top, both standalone
// - deglitch pins: none, 80ms, 625ms, 1.25s, 2.5s, 5s, 10s; 111 reserved
// - chain enable high runs the device, low puts it in standby
// - grouping pin high gives three separate alarms, low one shared alarm
`ifndef CSA_REGS_SVH
`define CSA_REGS_SVH
`define CSA_CLK_HZ 100000000
`define CSA_DG_80_MS 80
`define CSA_DG_625_MS 625
`define CSA_DG_1250_MS 1250
`define CSA_DG_2500_MS 2500
`define CSA_DG_5000_MS 5000
`define CSA_DG_10000_MS 10000
`define CSA_CYC_PER_MS (`CSA_CLK_HZ / 1000)
`define CSA_CELLS 6
`define CSA_TEMPS 2
`define CSA_ST_CYCLES 16
`endif

// file: csa_pkg.sv
// types of the cell stack alarm logic
package csa_pkg;
  typedef enum logic [1:0] {
    CSA_ROLE_MIDDLE,
    CSA_ROLE_BOTTOM,
    CSA_ROLE_TOP,
    CSA_ROLE_SINGLE
  } csa_role_t;
  typedef enum logic [1:0] {
    CSA_ST_IDLE,
    CSA_ST_FORCE,
    CSA_ST_CHECK,
    CSA_ST_REPORT
  } csa_st_t;
  typedef logic [2:0] csa_alarm_t;
endpackage

// file: csa_dg_if.sv
// interface between the alarm logic and one deglitch filter
`timescale 1ns/10ps
interface csa_dg_if;
  logic raw;
  logic filt;
  modport ctl(output raw, input filt);
  modport flt(input raw, output filt);
endinterface

// file: csa_deglitch.sv
// persistence filter for one alarm condition
`timescale 1ns/10ps
module csa_deglitch #(
  parameter int CW = 30
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [CW-1:0] i_limit,
  csa_dg_if.flt dg
);
  import csa_pkg::*;
  logic [CW-1:0] cnt_q;
  logic filt_q;
  assign dg.filt = filt_q;
  // ---------------------------------------------
  // count persistence
  // ---------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (!dg.raw) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (cnt_q >= i_limit) begin
      filt_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// file: csa_top.sv
// decision and configuration logic of the cell stack alarm monitor
`timescale 1ns/10ps
`include "csa_regs.svh"
module csa_top #(
  parameter int DG_80_CYC = `CSA_DG_80_MS * `CSA_CYC_PER_MS,
  parameter int DG_625_CYC = `CSA_DG_625_MS * `CSA_CYC_PER_MS,
  parameter int DG_1250_CYC = `CSA_DG_1250_MS * `CSA_CYC_PER_MS,
  parameter int DG_2500_CYC = `CSA_DG_2500_MS * `CSA_CYC_PER_MS,
  parameter int DG_5000_CYC = `CSA_DG_5000_MS * `CSA_CYC_PER_MS,
  parameter int DG_10000_CYC = `CSA_DG_10000_MS * `CSA_CYC_PER_MS,
  parameter int ST_CYC = `CSA_ST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cell_count_pick_a,
  input wire logic i_cell_count_pick_b,
  input wire logic i_thermistor_polarity_pick,
  input wire logic i_alarm_grouping_pick,
  input wire logic i_glitch_time_pick_a,
  input wire logic i_glitch_time_pick_b,
  input wire logic i_glitch_time_pick_c,
  input wire logic i_chain_lower_end_strap,
  input wire logic i_chain_upper_end_strap,
  input wire logic i_chain_enable_in,
  input wire logic i_selftest_request_in,
  input wire logic [5:0] i_cell_above_high,
  input wire logic [5:0] i_cell_below_low,
  input wire logic [1:0] i_temp_above_trip,
  input wire csa_pkg::csa_alarm_t i_alarm_current_in,
  input wire logic [2:0] i_selftest_seen,
  output logic [2:0] o_selftest_force,
  output csa_pkg::csa_alarm_t o_alarm_level_out,
  output csa_pkg::csa_alarm_t o_alarm_current_out,
  output logic o_chain_enable_out,
  output logic o_selftest_request_out,
  output logic o_active,
  output csa_pkg::csa_role_t o_role
);
  import csa_pkg::*;
  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  localparam int NS = 31;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  // every pin, most significant first
  assign pin_raw = {
    i_cell_count_pick_a,
    i_cell_count_pick_b,
    i_thermistor_polarity_pick,
    i_alarm_grouping_pick,
    i_glitch_time_pick_a,
    i_glitch_time_pick_b,
    i_glitch_time_pick_c,
    i_chain_lower_end_strap,
    i_chain_upper_end_strap,
    i_chain_enable_in,
    i_selftest_request_in,
    i_cell_above_high,
    i_cell_below_low,
    i_temp_above_trip,
    i_alarm_current_in,
    i_selftest_seen
  };
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end
  logic sel_a, sel_b, pol, grp, dga, dgb, dgc, lo_end, hi_end, en, treq;
  logic [5:0] ov_raw, uv_raw;
  logic [1:0] tabove;
  logic [2:0] chain_in, st_seen;
  // only the second stage is read past the synchroniser
  assign sel_a = s2_q[30];
  assign sel_b = s2_q[29];
  assign pol = s2_q[28];
  assign grp = s2_q[27];
  assign dga = s2_q[26];
  assign dgb = s2_q[25];
  assign dgc = s2_q[24];
  assign lo_end = s2_q[23];
  assign hi_end = s2_q[22];
  assign en = s2_q[21];
  assign treq = s2_q[20];
  assign ov_raw = s2_q[19:14];
  assign uv_raw = s2_q[13:8];
  assign tabove = s2_q[7:6];
  assign chain_in = s2_q[5:3];
  assign st_seen = s2_q[2:0];
  // ---------------------------------------------
  // configuration capture
  // ---------------------------------------------
  logic cfg_done_q;
  logic [5:0] cell_en_q;
  logic pol_q, grp_q;
  logic [2:0] dg_sel_q;
  csa_role_t role_q;
  logic [1:0] vld_q;
  // stage two holds real pin levels from the second edge after reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vld_q <= 2'h0;
    end else begin
      vld_q <= {vld_q[0], 1'b1};
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_done_q <= 1'b0;
      cell_en_q <= 6'h3F;
      pol_q <= 1'b0;
      grp_q <= 1'b0;
      dg_sel_q <= 3'h0;
      role_q <= CSA_ROLE_SINGLE;
    end else if (!cfg_done_q && vld_q[1]) begin
      cfg_done_q <= 1'b1;
      unique case ({sel_a, sel_b})
        2'b00: cell_en_q <= 6'h3F;
        2'b01: cell_en_q <= 6'h1F;
        2'b10: cell_en_q <= 6'h0F;
        2'b11: cell_en_q <= 6'h07;
      endcase
      pol_q <= pol;
      grp_q <= grp;
      dg_sel_q <= {dga, dgb, dgc};
      unique case ({hi_end, lo_end})
        2'b00: role_q <= CSA_ROLE_MIDDLE;
        2'b01: role_q <= CSA_ROLE_BOTTOM;
        2'b10: role_q <= CSA_ROLE_TOP;
        2'b11: role_q <= CSA_ROLE_SINGLE;
      endcase
    end
  end
  // ---------------------------------------------
  // window comparison
  // ---------------------------------------------
  logic [2:0] cond;
  logic [1:0] thermal;
  assign thermal = pol_q ? tabove : ~tabove;
  assign cond[0] = |(ov_raw & cell_en_q);
  assign cond[1] = |(uv_raw & cell_en_q);
  assign cond[2] = |thermal;
  // ---------------------------------------------
  // deglitch filters
  // ---------------------------------------------
  logic [29:0] dg_limit;
  always_comb begin
    unique case (dg_sel_q)
      3'b000: dg_limit = 30'h0;
      3'b001: dg_limit = 30'(DG_80_CYC);
      3'b010: dg_limit = 30'(DG_625_CYC);
      3'b011: dg_limit = 30'(DG_1250_CYC);
      3'b100: dg_limit = 30'(DG_2500_CYC);
      3'b101: dg_limit = 30'(DG_5000_CYC);
      3'b110: dg_limit = 30'(DG_10000_CYC);
      default: dg_limit = 30'h0;
    endcase
  end
  logic run;
  logic [2:0] filt;
  assign run = cfg_done_q && en;
  for (genvar g = 0; g < 3; g++) begin : g_dg
    csa_dg_if dgi();
    assign dgi.raw = run && cond[g];
    assign filt[g] = dgi.filt;
    csa_deglitch #(.CW(30)) u_dg (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_limit(dg_limit),
      .dg(dgi.flt)
    );
  end
  // ---------------------------------------------
  // self-test sequencer
  // ---------------------------------------------
  csa_st_t st_q;
  logic treq_q;
  logic [7:0] st_cnt_q;
  logic st_pass_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= CSA_ST_IDLE;
      treq_q <= 1'b0;
      st_cnt_q <= 8'h0;
      st_pass_q <= 1'b0;
    end else begin
      treq_q <= treq;
      unique case (st_q)
        CSA_ST_IDLE: begin
          if (run && treq && !treq_q) begin
            st_q <= CSA_ST_FORCE;
            st_cnt_q <= 8'h0;
          end
        end
        CSA_ST_FORCE: begin
          st_cnt_q <= st_cnt_q + 8'h01;
          if (st_cnt_q == 8'(ST_CYC - 1)) begin
            st_q <= CSA_ST_CHECK;
          end
        end
        CSA_ST_CHECK: begin
          st_pass_q <= &st_seen;
          st_cnt_q <= 8'h0;
          st_q <= CSA_ST_REPORT;
        end
        CSA_ST_REPORT: begin
          st_cnt_q <= st_cnt_q + 8'h01;
          if (st_cnt_q == 8'(ST_CYC - 1) || !run) begin
            st_q <= CSA_ST_IDLE;
          end
        end
      endcase
    end
  end
  // ---------------------------------------------
  // alarm outputs and chain
  // ---------------------------------------------
  csa_alarm_t local_al, from_above, merged;
  // ---------------------------------------------
  // chain role decode
  // ---------------------------------------------
  logic take_chain;
  logic fwd_up;
  always_comb begin
    unique case (role_q)
      CSA_ROLE_MIDDLE: begin
        take_chain = 1'b1;
        fwd_up = 1'b1;
      end
      CSA_ROLE_BOTTOM: begin
        take_chain = 1'b1;
        fwd_up = 1'b1;
      end
      CSA_ROLE_TOP: begin
        take_chain = 1'b0;
        fwd_up = 1'b0;
      end
      CSA_ROLE_SINGLE: begin
        take_chain = 1'b0;
        fwd_up = 1'b0;
      end
    endcase
  end
  // standby clears the chain alarms as well as the local ones
  assign from_above = (take_chain && run) ? chain_in : 3'h0;
  assign local_al = filt | from_above;
  always_comb begin
    if (st_q == CSA_ST_REPORT) begin
      merged = st_pass_q ? 3'h0 : 3'h7;
    end else if (st_q != CSA_ST_IDLE) begin
      merged = 3'h0;
    end else if (grp_q) begin
      merged = local_al;
    end else begin
      merged = {3{|local_al}};
    end
  end
  // ---------------------------------------------
  // output registers
  // ---------------------------------------------
  // alarm levels and chain currents
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alarm_level_out <= 3'h0;
      o_alarm_current_out <= 3'h0;
    end else begin
      o_alarm_level_out <= merged;
      o_alarm_current_out <= merged;
    end
  end
  // self-test force
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_selftest_force <= 3'h0;
    end else begin
      o_selftest_force <= (st_q == CSA_ST_FORCE) ? 3'h7 : 3'h0;
    end
  end
  // requests passed up the chain
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chain_enable_out <= 1'b0;
      o_selftest_request_out <= 1'b0;
    end else begin
      o_chain_enable_out <= cfg_done_q && en && fwd_up;
      o_selftest_request_out <= cfg_done_q && treq && fwd_up;
    end
  end
  // status
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_active <= 1'b0;
      o_role <= CSA_ROLE_SINGLE;
    end else begin
      o_active <= run;
      o_role <= role_q;
    end
  end
endmodule

// file: csa_top_monitor.sv
// concurrent checks on the ports of the cell stack alarm logic
`timescale 1ns/10ps
module csa_top_mon #(
  parameter int ST_CYC = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_chain_lower_end_strap,
  input wire logic i_chain_upper_end_strap,
  input wire logic i_chain_enable_in,
  input wire logic i_selftest_request_in,
  input wire logic i_alarm_grouping_pick,
  input wire logic [2:0] o_selftest_force,
  input wire csa_pkg::csa_alarm_t o_alarm_level_out,
  input wire csa_pkg::csa_alarm_t o_alarm_current_out,
  input wire logic o_chain_enable_out,
  input wire logic o_selftest_request_out,
  input wire logic o_active,
  input wire csa_pkg::csa_role_t o_role
);
  import csa_pkg::*;
  int unsigned frc_q;
  // length of the current force phase
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      frc_q <= 0;
    else
      frc_q <= o_selftest_force[0] ? frc_q + 1 : 0;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  AST_ROLE: assert property (o_active && $past(o_active) |->
    o_role == csa_role_t'({i_chain_upper_end_strap, i_chain_lower_end_strap}))
    else $error("role does not match straps");
  AST_MIRROR: assert property (o_alarm_current_out == o_alarm_level_out)
    else $error("current alarm differs from level alarm");
  AST_SHARED: assert property (o_active && !i_alarm_grouping_pick |->
    o_alarm_level_out inside {3'h0, 3'h7}) else $error("shared alarms differ");
  AST_STANDBY: assert property ((!i_chain_enable_in) [*5] |->
    o_alarm_level_out == 3'h0 && !o_chain_enable_out) else $error("standby not kept");
  AST_FWD: assert property ((!i_chain_upper_end_strap && i_chain_enable_in) [*8] |->
    o_chain_enable_out) else $error("enable not forwarded");
  AST_TOP: assert property (i_chain_upper_end_strap && o_active && $past(o_active) |->
    !o_chain_enable_out && !o_selftest_request_out) else $error("top forwards requests");
  AST_TLEN: assert property ($fell(o_selftest_force[0]) |-> frc_q == ST_CYC)
    else $error("force phase length wrong");
  AST_TREQ: assert property ($rose(o_selftest_force[0]) |->
    $past(i_selftest_request_in, 3) || $past(i_selftest_request_in, 4))
    else $error("self-test without request");
  AST_TQUIET: assert property (o_selftest_force[0] |->
    o_selftest_force == 3'h7 && o_alarm_level_out == 3'h0) else $error("force phase not quiet");
  cover property ($fell(o_selftest_force[0]));
  cover property (!i_alarm_grouping_pick && o_alarm_level_out == 3'h7);
  cover property ((!i_chain_enable_in) [*5]);
endmodule
bind csa_top csa_top_mon #(.ST_CYC(ST_CYC)) mon (.*);

// file: csa_chain_peer.sv
// model of the next higher monitor in the chain
`timescale 1ns/10ps
module csa_chain_peer (
  input wire logic i_clk,
  input wire logic i_enable,
  input wire logic [2:0] i_alarm_cmd,
  output csa_pkg::csa_alarm_t o_alarm_current_out
);
  // a neighbour in standby sources no alarm current
  always_ff @(posedge i_clk) begin
    o_alarm_current_out <= i_enable ? i_alarm_cmd : 3'h0;
  end
endmodule

// file: test_csa_top.sv
// self-checking bench of the cell stack alarm logic
`timescale 1ns/10ps
module test_csa_top;
  import csa_pkg::*;
  logic clk = 0, rst_n = 0, pol = 0, grp = 0, en = 1, req = 0, en_o, req_o, act, slow = 0;
  logic [1:0] cc = 0, strap = 0, temp = 0;
  logic [2:0] dg = 0, seen = 0, up_cmd = 0, force_o;
  logic [5:0] hi = 0, lo = 0;
  csa_alarm_t chain_in, lvl, cur;
  csa_role_t role;
  integer seed = 95, miscompares = 0, checked = 0, lim = 0;
  always #5 clk = ~clk;
  // the longest filter and the self-test phases keep their full lengths
  csa_top #(.DG_80_CYC(10), .DG_625_CYC(20), .DG_1250_CYC(30), .DG_2500_CYC(40),
    .DG_5000_CYC(50)) uut (.i_clk(clk), .i_arst_n(rst_n),
    .i_cell_count_pick_a(cc[1]), .i_cell_count_pick_b(cc[0]),
    .i_thermistor_polarity_pick(pol), .i_alarm_grouping_pick(grp),
    .i_glitch_time_pick_a(dg[2]), .i_glitch_time_pick_b(dg[1]), .i_glitch_time_pick_c(dg[0]),
    .i_chain_lower_end_strap(strap[0]), .i_chain_upper_end_strap(strap[1]),
    .i_chain_enable_in(en), .i_selftest_request_in(req), .i_cell_above_high(hi),
    .i_cell_below_low(lo), .i_temp_above_trip(temp), .i_alarm_current_in(chain_in),
    .i_selftest_seen(seen), .o_selftest_force(force_o), .o_alarm_level_out(lvl),
    .o_alarm_current_out(cur), .o_chain_enable_out(en_o), .o_selftest_request_out(req_o),
    .o_active(act), .o_role(role));
  csa_chain_peer peer (.i_clk(clk), .i_enable(en_o), .i_alarm_cmd(up_cmd),
    .o_alarm_current_out(chain_in));
  function automatic csa_alarm_t exp_alarm();
    logic [5:0] m;
    logic [2:0] a;
    m = 6'h3F >> cc;
    a = {pol ? |temp : ~&temp, |(lo & m), |(hi & m)};
    // the longest filter never matures within the bench
    if (slow)
      a = 3'h0;
    if (!strap[1])
      a = a | up_cmd;
    return grp ? a : {3{|a}};
  endfunction
  task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic restart(input int i);
    rst_n = 0;
    dg = i[2:0];
    cc = i[1:0];
    strap = i[2:1];
    {pol, grp} = 2'($random(seed));
    temp = {2{~pol}};
    {hi, lo, up_cmd} = '0;
    lim = (i == 0 || i == 7) ? 0 : (i == 6) ? 100 : i * 10;
    slow = (i == 6);
    tick(5);
    cmp({1'b0, role}, 3'h3);
    rst_n = 1;
    tick(8);
  endtask
  // ----------------------------------------
  // scenarios, one reset per configuration
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      restart(i);
      cmp({1'b0, role}, {1'b0, strap});
      cmp({2'b0, act}, 3'h1);
      cmp({2'b0, en_o}, {2'b0, !strap[1]});
      if (lim > 0) begin
        hi = 6'h01;
        tick(3);
        hi = 0;
        tick(lim + 6);
        cmp(lvl, 3'h0);
      end
      hi = 6'h01;
      tick(lim + 2);
      cmp(lvl, 3'h0);
      tick(4);
      cmp(lvl, exp_alarm());
      repeat (6) begin
        {hi, lo, temp, up_cmd} = 17'($random(seed));
        tick(lim + 8);
        cmp(lvl, exp_alarm());
        cmp(cur, exp_alarm());
      end
      en = 0;
      tick(6);
      cmp(lvl, 3'h0);
      {hi, lo, up_cmd} = '0;
      temp = {2{~pol}};
      en = 1;
      tick(12);
      cmp(lvl, 3'h0);
      seen = i[0] ? 3'h7 : 3'h5;
      req = 1;
      tick(6);
      cmp(force_o, 3'h7);
      cmp({2'b0, req_o}, {2'b0, !strap[1]});
      req = 0;
      tick(17);
      cmp(lvl, i[0] ? 3'h0 : 3'h7);
      tick(20);
    end
    give_verdict();
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
